//--- psr_soft_reset_ctrl.sv
// Purpose: soft reset control words behind an AXI4-Lite slave
// Assumes: capability words are static levels from the same clock domain
// Notes:   read data from an absent unit's bit is zero
//
// Operation
// - Writes to control word a are masked by capability word one.
// - Writes to control word b are masked by capability word two.
// - Word a has reset bits: CAN 24, converter 16, watchdog 3.
// - Word b has comparator reset bits 2,1,0 at 26,25,24.
// - Word b has timer reset bits 2,1,0 at 18,17,16.
// - Word b: two-wire reset bit 12, synchronous serial bit 4.
// - Word b: serial port 1 at bit 1, port 0 at bit 0.
// - Unassigned bits are read-only zero; software preserves them.
// - Both words clear to zero after chip reset.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module psr_soft_reset_ctrl
  import psr_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // write address channel
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [PSR_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  // write data channel
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  // write response channel
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic      [1:0]            s_axi_bresp,
  // read address channel
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [PSR_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  // read data channel
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  // capability words
  input  wire logic [31:0]           capability_word_one,
  input  wire logic [31:0]           capability_word_two,
  // peripheral reset requests, active high
  output logic                       ctrl_area_net_reset_bit,
  output logic                       converter_reset_bit,
  output logic                       watchdog_reset_bit,
  output logic                       comparator_two_reset_bit,
  output logic                       comparator_one_reset_bit,
  output logic                       comparator_zero_reset_bit,
  output logic                       counter_module_two_reset_bit,
  output logic                       counter_module_one_reset_bit,
  output logic                       counter_module_zero_reset_bit,
  output logic                       two_wire_reset_bit,
  output logic                       sync_serial_reset_bit,
  output logic                       serial_port_one_reset_bit,
  output logic                       serial_port_zero_reset_bit
);
  import psr_pkg::*;

  // write channel capture
  logic                  aw_held_q;
  logic [PSR_ADDR_W-1:0] aw_addr_q;
  logic                  w_held_q;
  logic [31:0]           w_data_q;
  logic [3:0]            w_strb_q;

  wire                   aw_take = s_axi_awvalid && s_axi_awready;
  wire                   w_take  = s_axi_wvalid && s_axi_wready;
  wire                   wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;

  // write decode
  wire                   wr_hit_a   = (aw_addr_q == PSR_OFF_CTRL_A);
  wire                   wr_hit_b   = (aw_addr_q == PSR_OFF_CTRL_B);
  wire                   wr_hit_cap = (aw_addr_q == PSR_OFF_CAP_ONE) ||
                                      (aw_addr_q == PSR_OFF_CAP_TWO);
  wire                   wr_mapped  = wr_hit_a || wr_hit_b || wr_hit_cap;
  wire                   wr_en_a    = wr_fire && wr_hit_a;
  wire                   wr_en_b    = wr_fire && wr_hit_b;

  logic [31:0]           ctrl_a_q;
  logic [31:0]           ctrl_b_q;

  // word a masked by capability one
  psr_ctrl_word #(
    .IMPL_MASK (PSR_A_IMPL_MASK)
  ) u_ctrl_a (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_en    (wr_en_a),
    .wr_data  (w_data_q),
    .wr_strb  (w_strb_q),
    .cap_word (capability_word_one),
    .word_q   (ctrl_a_q)
  );

  // word b masked by capability two
  psr_ctrl_word #(
    .IMPL_MASK (PSR_B_IMPL_MASK)
  ) u_ctrl_b (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .wr_en    (wr_en_b),
    .wr_data  (w_data_q),
    .wr_strb  (w_strb_q),
    .cap_word (capability_word_two),
    .word_q   (ctrl_b_q)
  );

  wire [31:0] view_a = ctrl_a_q & capability_word_one & PSR_A_IMPL_MASK;
  wire [31:0] view_b = ctrl_b_q & capability_word_two & PSR_B_IMPL_MASK;

  logic [PSR_ADDR_W-1:0] aw_word_addr;
  assign aw_word_addr = {s_axi_awaddr[PSR_ADDR_W-1:2], 2'b00};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
    end else if (aw_take) begin
      aw_held_q <= 1'b1;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_q <= '0;
    end else if (aw_take) begin
      aw_addr_q <= aw_word_addr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
    end else if (w_take) begin
      w_held_q <= 1'b1;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (w_take) begin
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
  end

  // one write in flight: each ready only while its own channel holds nothing and no response is pending
  logic                  wr_busy;
  logic                  aw_ready_d;
  logic                  w_ready_d;
  assign wr_busy    = s_axi_bvalid || wr_fire;
  assign aw_ready_d = !aw_held_q && !aw_take && !wr_busy;
  assign w_ready_d  = !w_held_q && !w_take && !wr_busy;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= aw_ready_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= w_ready_d;
    end
  end

  logic [1:0]            wr_resp_code;
  logic                  b_done;
  assign wr_resp_code = wr_mapped ? PSR_RESP_OKAY : PSR_RESP_SLVERR;
  assign b_done       = s_axi_bvalid && s_axi_bready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (b_done) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= PSR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_resp_code;
    end
  end

  // read decode
  wire [PSR_ADDR_W-1:0] rd_addr   = {s_axi_araddr[PSR_ADDR_W-1:2], 2'b00};
  wire                  rd_hit_a  = (rd_addr == PSR_OFF_CTRL_A);
  wire                  rd_hit_b  = (rd_addr == PSR_OFF_CTRL_B);
  wire                  rd_hit_c1 = (rd_addr == PSR_OFF_CAP_ONE);
  wire                  rd_hit_c2 = (rd_addr == PSR_OFF_CAP_TWO);
  wire                  rd_mapped = rd_hit_a || rd_hit_b || rd_hit_c1 || rd_hit_c2;
  wire                  ar_take   = s_axi_arvalid && s_axi_arready;
  wire [31:0]           rd_word   = rd_hit_a  ? view_a :
                                    rd_hit_b  ? view_b :
                                    rd_hit_c1 ? capability_word_one :
                                    rd_hit_c2 ? capability_word_two : 32'h0000_0000;

  // arready pulses one cycle at a time while no read data waits
  logic                  ar_ready_d;
  assign ar_ready_d = !s_axi_rvalid && !ar_take && !s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= ar_ready_d;
    end
  end

  logic [1:0]            rd_resp_code;
  logic                  r_done;
  assign rd_resp_code = rd_mapped ? PSR_RESP_OKAY : PSR_RESP_SLVERR;
  assign r_done       = s_axi_rvalid && s_axi_rready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (r_done) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PSR_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp_code;
    end
  end

  logic                  can_rst_d;
  logic                  conv_rst_d;
  logic                  wdog_rst_d;
  assign can_rst_d  = view_a[PSR_A_CAN_BIT];
  assign conv_rst_d = view_a[PSR_A_CONV_BIT];
  assign wdog_rst_d = view_a[PSR_A_WDOG_BIT];

  logic                  cmp2_rst_d;
  logic                  cmp1_rst_d;
  logic                  cmp0_rst_d;
  assign cmp2_rst_d = view_b[PSR_B_CMP2_BIT];
  assign cmp1_rst_d = view_b[PSR_B_CMP1_BIT];
  assign cmp0_rst_d = view_b[PSR_B_CMP0_BIT];

  logic                  tmr2_rst_d;
  logic                  tmr1_rst_d;
  logic                  tmr0_rst_d;
  assign tmr2_rst_d = view_b[PSR_B_TMR2_BIT];
  assign tmr1_rst_d = view_b[PSR_B_TMR1_BIT];
  assign tmr0_rst_d = view_b[PSR_B_TMR0_BIT];

  logic                  twi_rst_d;
  logic                  sync_rst_d;
  assign twi_rst_d  = view_b[PSR_B_TWI_BIT];
  assign sync_rst_d = view_b[PSR_B_SSI_BIT];

  logic                  ser1_rst_d;
  logic                  ser0_rst_d;
  assign ser1_rst_d = view_b[PSR_B_SER1_BIT];
  assign ser0_rst_d = view_b[PSR_B_SER0_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_area_net_reset_bit       <= 1'b0;
      converter_reset_bit           <= 1'b0;
      watchdog_reset_bit            <= 1'b0;
    end else begin
      ctrl_area_net_reset_bit       <= can_rst_d;
      converter_reset_bit           <= conv_rst_d;
      watchdog_reset_bit            <= wdog_rst_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      comparator_two_reset_bit      <= 1'b0;
      comparator_one_reset_bit      <= 1'b0;
      comparator_zero_reset_bit     <= 1'b0;
    end else begin
      comparator_two_reset_bit      <= cmp2_rst_d;
      comparator_one_reset_bit      <= cmp1_rst_d;
      comparator_zero_reset_bit     <= cmp0_rst_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_module_two_reset_bit  <= 1'b0;
      counter_module_one_reset_bit  <= 1'b0;
      counter_module_zero_reset_bit <= 1'b0;
    end else begin
      counter_module_two_reset_bit  <= tmr2_rst_d;
      counter_module_one_reset_bit  <= tmr1_rst_d;
      counter_module_zero_reset_bit <= tmr0_rst_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      two_wire_reset_bit            <= 1'b0;
      sync_serial_reset_bit         <= 1'b0;
    end else begin
      two_wire_reset_bit            <= twi_rst_d;
      sync_serial_reset_bit         <= sync_rst_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_port_one_reset_bit     <= 1'b0;
      serial_port_zero_reset_bit    <= 1'b0;
    end else begin
      serial_port_one_reset_bit     <= ser1_rst_d;
      serial_port_zero_reset_bit    <= ser0_rst_d;
    end
  end
endmodule
`default_nettype wire

//--- psr_pkg.sv
// Purpose: constants for the peripheral soft reset controller
// Assumes: 32-bit register words on AXI4-Lite, byte addresses
// Notes:   capability words are inputs from the system control block
package psr_pkg;

  localparam int          PSR_ADDR_W         = 12;
  localparam int          PSR_DATA_W         = 32;

  // register byte offsets
  localparam logic [11:0] PSR_OFF_CTRL_A     = 12'h040;
  localparam logic [11:0] PSR_OFF_CTRL_B     = 12'h044;
  localparam logic [11:0] PSR_OFF_CAP_ONE    = 12'h048;
  localparam logic [11:0] PSR_OFF_CAP_TWO    = 12'h04c;

  localparam logic [31:0] PSR_RESET_VAL      = 32'h0000_0000;

  // control word a bit positions
  localparam int          PSR_A_CAN_BIT      = 24;
  localparam int          PSR_A_CONV_BIT     = 16;
  localparam int          PSR_A_WDOG_BIT     = 3;

  // control word b bit positions
  localparam int          PSR_B_CMP2_BIT     = 26;
  localparam int          PSR_B_CMP1_BIT     = 25;
  localparam int          PSR_B_CMP0_BIT     = 24;
  localparam int          PSR_B_TMR2_BIT     = 18;
  localparam int          PSR_B_TMR1_BIT     = 17;
  localparam int          PSR_B_TMR0_BIT     = 16;
  localparam int          PSR_B_TWI_BIT      = 12;
  localparam int          PSR_B_SSI_BIT      = 4;
  localparam int          PSR_B_SER1_BIT     = 1;
  localparam int          PSR_B_SER0_BIT     = 0;

  // implemented bits of each control word
  localparam logic [31:0] PSR_A_IMPL_MASK    = 32'h0101_0008;
  localparam logic [31:0] PSR_B_IMPL_MASK    = 32'h0707_1013;

  // axi responses
  localparam logic [1:0]  PSR_RESP_OKAY      = 2'b00;
  localparam logic [1:0]  PSR_RESP_SLVERR    = 2'b10;

endpackage

//--- psr_ctrl_word.sv
// Purpose: one masked soft reset control word
// Assumes: write strobe is a one-cycle pulse on aclk
// Notes:   bits outside impl_mask or the capability word stay zero
`timescale 1ns/1ps
`default_nettype none
module psr_ctrl_word
  import psr_pkg::*;
#(
  parameter logic [31:0] IMPL_MASK = 32'h0000_0000
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write side
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [3:0]  wr_strb,
  input  wire logic [31:0] cap_word,
  // state
  output logic      [31:0] word_q
);
  logic [31:0] lane_mask;
  logic [31:0] write_mask;
  logic [31:0] word_d;

  assign lane_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign write_mask = lane_mask & IMPL_MASK & cap_word;
  assign word_d     = wr_en ? (((word_q & ~write_mask) | (wr_data & write_mask)) & IMPL_MASK)
                            : word_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_q <= PSR_RESET_VAL;
    end else begin
      word_q <= word_d;
    end
  end
endmodule
`default_nettype wire

//--- psr_soft_reset_ctrl_sva.sv
// Purpose: port checker for the soft reset controller
// Assumes: one aclk domain, aresetn synchronous active low
// Notes:   bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module psr_soft_reset_ctrl_sva
  import psr_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // capability and reset outputs
  input wire logic [31:0] capability_word_one,
  input wire logic [31:0] capability_word_two,
  input wire logic        ctrl_area_net_reset_bit,
  input wire logic        converter_reset_bit,
  input wire logic        watchdog_reset_bit,
  input wire logic        comparator_two_reset_bit,
  input wire logic        comparator_one_reset_bit,
  input wire logic        comparator_zero_reset_bit,
  input wire logic        counter_module_two_reset_bit,
  input wire logic        counter_module_one_reset_bit,
  input wire logic        counter_module_zero_reset_bit,
  input wire logic        two_wire_reset_bit,
  input wire logic        sync_serial_reset_bit,
  input wire logic        serial_port_one_reset_bit,
  input wire logic        serial_port_zero_reset_bit
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic [12:0] ro = {ctrl_area_net_reset_bit, converter_reset_bit, watchdog_reset_bit,
    comparator_two_reset_bit, comparator_one_reset_bit, comparator_zero_reset_bit,
    counter_module_two_reset_bit, counter_module_one_reset_bit, counter_module_zero_reset_bit,
    two_wire_reset_bit, sync_serial_reset_bit, serial_port_one_reset_bit,
    serial_port_zero_reset_bit};
  wire logic [31:0] c1 = capability_word_one;
  wire logic [31:0] c2 = capability_word_two;
  wire logic [12:0] cp = {c1[24], c1[16], c1[3], c2[26], c2[25], c2[24], c2[18], c2[17],
    c2[16], c2[12], c2[4], c2[1], c2[0]};
  rst_clear_a: assert property (
    $rose(aresetn) |-> ro == 13'h0) else $error("reset outputs not clear");
  cap_gate_a: assert property (
    (ro & ~cp) == 13'h0) else $error("absent unit held in reset");
  out_hold_a: assert property (
    $changed(ro) |-> $past(s_axi_bvalid)) else $error("reset output moved without write");
  wr_lat_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rd_lat_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  busy_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(watchdog_reset_bit));
endmodule
`default_nettype wire

//--- psr_soft_reset_ctrl_test.sv
// Purpose: self-checking bench for the soft reset controller
// Assumes: capability words static after time zero
// Notes:   converter and serial port zero are absent units
`timescale 1ns/1ps
`default_nettype none
module psr_soft_reset_ctrl_test;
  import psr_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, capability_word_one, capability_word_two;
  logic        ctrl_area_net_reset_bit, converter_reset_bit, watchdog_reset_bit;
  logic        comparator_two_reset_bit, comparator_one_reset_bit, comparator_zero_reset_bit;
  logic        counter_module_two_reset_bit, counter_module_one_reset_bit;
  logic        counter_module_zero_reset_bit, two_wire_reset_bit, sync_serial_reset_bit;
  logic        serial_port_one_reset_bit, serial_port_zero_reset_bit;
  int          n_mismatch = 0;
  int          total_checks = 0;
  wire logic [12:0] outs = {ctrl_area_net_reset_bit, converter_reset_bit, watchdog_reset_bit,
    comparator_two_reset_bit, comparator_one_reset_bit, comparator_zero_reset_bit,
    counter_module_two_reset_bit, counter_module_one_reset_bit, counter_module_zero_reset_bit,
    two_wire_reset_bit, sync_serial_reset_bit, serial_port_one_reset_bit,
    serial_port_zero_reset_bit};
  psr_soft_reset_ctrl dut_u (.*);
  function automatic logic [12:0] ex(input logic [31:0] a, input logic [31:0] b);
    return {a[24], a[16], a[3], b[26], b[25], b[24], b[18], b[17], b[16], b[12], b[4], b[1],
      b[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    do @(posedge aclk); while (!s_axi_bvalid);
    // slave must hold the response while bready is low
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_reset_vals;
    rd(12'h040, 32'h0, 2'b00);
    rd(12'h044, 32'h0, 2'b00);
    chk({19'h0, outs}, 32'h0);
  endtask
  task automatic t_walk;
    logic [31:0] v;
    for (int i = 0; i < 32; i++) begin
      v = 32'h1 << i;
      wr(12'h040, v, 4'hf, 2'b00);
      wr(12'h044, v, 4'hf, 2'b00);
      rd(12'h040, v & 32'h0101_0008 & capability_word_one, 2'b00);
      rd(12'h044, v & 32'h0707_1013 & capability_word_two, 2'b00);
      chk({19'h0, outs}, {19'h0, ex(v & capability_word_one, v & capability_word_two)});
    end
  endtask
  task automatic t_strobe;
    wr(12'h044, 32'hffff_ffff, 4'hf, 2'b00);
    wr(12'h044, 32'h0, 4'h4, 2'b00);
    rd(12'h044, 32'h0700_1012, 2'b00);
    chk({19'h0, outs}, 32'h0000_038e);
  endtask
  task automatic t_unmapped;
    wr(12'h050, 32'hffff_ffff, 4'hf, 2'b10);
    rd(12'h050, 32'h0, 2'b10);
    wr(12'h048, 32'h0, 4'hf, 2'b00);
    rd(12'h048, capability_word_one, 2'b00);
    rd(12'h04c, capability_word_two, 2'b00);
  endtask
  task automatic t_midreset;
    wr(12'h040, 32'hffff_ffff, 4'hf, 2'b00);
    chk({19'h0, outs}, 32'h0000_178e);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({19'h0, outs}, 32'h0);
    rd(12'h040, 32'h0, 2'b00);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    #300000;
    n_mismatch++;
    test_done;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wstrb, s_axi_wdata} = '0;
    capability_word_one = 32'hfffe_ffff;
    capability_word_two = 32'hffff_fffe;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_vals;
    t_walk;
    t_strobe;
    t_unmapped;
    t_midreset;
    test_done;
  end
endmodule
bind psr_soft_reset_ctrl psr_soft_reset_ctrl_sva chk_u (.*);
`default_nettype wire
